// File: cci_card_cmd.sv
// Card command interpreter: APB registers, code execution and streaming
// between drive parameter store and a removable card controller.
// Assumes card controller and drive store run on ref_clk; only the card
// presence pin is asynchronous.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cci_card_cmd (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drive_reset,
  input  wire logic        card_present,
  input  wire logic        card_is_sd,
  input  wire logic        card_done,
  input  wire logic        card_err,
  output logic             card_req,
  output cci_pkg::cci_op_t card_op,
  output logic [9:0]       card_blk,
  output logic             card_fin,
  input  wire logic        src_valid,
  input  wire logic [15:0] src_id,
  input  wire logic [31:0] src_val,
  input  wire logic [31:0] src_dflt,
  input  wire logic        src_last,
  output logic             src_ready,
  output logic             cw_valid,
  output logic [15:0]      cw_id,
  output logic [31:0]      cw_val,
  input  wire logic        cw_ready,
  input  wire logic        cr_valid,
  input  wire logic [15:0] cr_id,
  input  wire logic [31:0] cr_val,
  input  wire logic        cr_last,
  input  wire logic        cr_legacy,
  input  wire logic        cr_diff,
  output logic             cr_ready,
  input  wire logic        par_exists,
  input  wire logic [31:0] par_min,
  input  wire logic [31:0] par_max,
  output logic             dw_valid,
  output logic [15:0]      dw_id,
  output logic [31:0]      dw_val,
  input  wire logic        dw_ready,
  output logic             busy,
  output logic             trip,
  output cci_pkg::cci_trip_t trip_code,
  output logic             ro_flag,
  output logic             warn_flag
);
  import cci_pkg::*;

  logic [1:0]  rst_q;
  logic        rst_n;
  logic        cp_meta_q, cp_q;
  cci_state_t  st_q, st_d;
  logic [13:0] cmd_q, cmd_d;
  cci_op_t     op_q, op_d;
  logic [9:0]  blk_q, blk_d;
  cci_trip_t   tc_q, tc_d;
  logic        trip_q, trip_d, ro_q, ro_d, warn_q, warn_d;
  logic        req_q, req_d, fin_q, fin_d;
  logic        srdy_q, srdy_d, crdy_q, crdy_d;
  logic        cwv_q, cwv_d, dwv_q, dwv_d;
  logic [15:0] cwi_q, cwi_d, dwi_q, dwi_d;
  logic [31:0] cwd_q, cwd_d, dwd_q, dwd_d;
  logic        af_q, af_d, bf_q, bf_d, al_q, al_d, bl_q, bl_d;
  logic [15:0] ai_q, ai_d, bi_q, bi_d;
  logic [31:0] ad_q, ad_d, bd_q, bd_d;
  logic [31:0] prd_q, prd_d;
  logic        prdy_q, prdy_d, perr_q, perr_d;
  logic        setup, acc_wr, exec, take_a, take_b, save, keep;
  logic [31:0] clamped;
  cci_cmd_if   cmd_if ();

  // Decodes the stored command parameter continuously.
  assign cmd_if.code = cmd_q;
  cci_decode u_dec (.c(cmd_if.dec));

  // Reset release and card presence pass two flops each.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_meta_q <= 1'b0;
      cp_q      <= 1'b0;
    end else begin
      cp_meta_q <= card_present;
      cp_q      <= cp_meta_q;
    end
  end

  // Signed clamp of a loaded value into the target range.
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    if ($signed(v) < $signed(lo)) begin
      return lo;
    end else if ($signed(v) > $signed(hi)) begin
      return hi;
    end
    return v;
  endfunction : clamp

  // Bus phase decode; every access finishes on its first access edge.
  always_comb begin
    setup   = psel && !penable;
    acc_wr  = psel && penable && prdy_q && pwrite;
    exec    = drive_reset || (acc_wr && paddr == CCI_ADDR_CTRL &&
              pwdata[CCI_CTRL_EXEC]);  // RULE1
    save    = op_q inside {OP_SAVE_BOOT, OP_SAVE_PAR, OP_SAVE_PRG};
    take_a  = src_valid && srdy_q;
    take_b  = cr_valid && crdy_q;
    keep    = (op_q != OP_SAVE_PAR) || (src_val != src_dflt);  // RULE4
    clamped = cr_legacy ? clamp(cr_val, par_min, par_max) : cr_val;
  end

  // Register file: read data, ready and error are set in the setup cycle.
  always_comb begin
    prdy_d = setup;
    prd_d  = 32'h0000_0000;
    perr_d = 1'b0;
    if (setup) begin
      unique case (paddr)
        CCI_ADDR_CMD: begin
          prd_d  = {18'h0_0000, cmd_q};
          perr_d = pwrite && ((st_q != ST_IDLE) ||
                   (pwdata[13:0] > CCI_CMD_MAX) ||
                   (pwdata[31:14] != 18'h0_0000));  // RULE19
        end
        CCI_ADDR_CTRL: prd_d = 32'h0000_0000;
        CCI_ADDR_STATUS: begin
          prd_d[CCI_ST_BUSY] = (st_q != ST_IDLE);
          prd_d[CCI_ST_RO]   = ro_q;
          prd_d[CCI_ST_WARN] = warn_q;
          prd_d[CCI_ST_CARD] = cp_q;
          prd_d[CCI_ST_TRIP+:3] = tc_q;
        end
        default: perr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prd_q  <= 32'h0000_0000;
      prdy_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      prd_q  <= prd_d;
      prdy_q <= prdy_d;
      perr_q <= perr_d;
    end
  end

  // Sequencer and stream datapath.
  always_comb begin
    st_d = st_q;   cmd_d = cmd_q;  op_d = op_q;   blk_d = blk_q;
    tc_d = tc_q;   trip_d = trip_q; ro_d = ro_q;  warn_d = warn_q;
    req_d = req_q; fin_d = 1'b0;
    cwv_d = cwv_q; cwi_d = cwi_q;  cwd_d = cwd_q;
    dwv_d = dwv_q; dwi_d = dwi_q;  dwd_d = dwd_q;
    af_d = af_q;   ai_d = ai_q;    ad_d = ad_q;   al_d = al_q;
    bf_d = bf_q;   bi_d = bi_q;    bd_d = bd_q;   bl_d = bl_q;
    // A code write is only accepted while idle.
    if (acc_wr && paddr == CCI_ADDR_CMD && !perr_q) begin
      cmd_d = pwdata[13:0];  // RULE1
    end
    unique case (st_q)
      ST_IDLE: begin
        if (exec && cmd_if.op != OP_NONE &&
            (!ro_q || cmd_if.op inside {OP_LOAD, OP_RO_CLR})) begin  // RULE11
          tc_d   = TRIP_NONE;
          trip_d = 1'b0;
          unique case (cmd_if.op)
            OP_WARN_SET: warn_d = 1'b1;  // RULE9
            OP_WARN_CLR: warn_d = 1'b0;  // RULE9
            OP_RO_SET:   ro_d = 1'b1;  // RULE10
            OP_RO_CLR:   ro_d = 1'b0;  // RULE10
            default: begin
              if (!cp_q) begin
                tc_d = TRIP_NOCARD;
              end else if (cmd_if.op == OP_FORMAT && card_is_sd) begin
                tc_d = TRIP_UNSUP;  // RULE7
              end else if (cmd_if.op != OP_FORMAT &&
                           (cmd_if.blk < CCI_BLK_MIN ||
                            cmd_if.blk > CCI_BLK_MAX)) begin
                tc_d = TRIP_BLOCK;  // RULE13
              end else begin
                st_d  = ST_XFER;
                req_d = 1'b1;  // RULE14
                op_d  = cmd_if.op;
                blk_d = cmd_if.blk;
              end
              trip_d = (tc_d != TRIP_NONE);
            end
          endcase
        end
      end
      ST_XFER: begin
        if (op_q inside {OP_ERASE, OP_FORMAT}) begin
          st_d = ST_CLOSE;  // RULE7
        end
        // Save: drive words go to the card, defaults filtered only for OP_SAVE_PAR.
        if (save) begin
          if (cwv_q && cw_ready) begin
            cwv_d = 1'b0;
            if (al_q) begin
              st_d = ST_CLOSE;
            end
          end
          if (take_a) begin
            al_d = src_last;
            if (keep) begin  // RULE4
              cwv_d = 1'b1;  // RULE2 RULE3 RULE5
              cwi_d = src_id;
              cwd_d = src_val;
            end else if (src_last) begin
              st_d = ST_CLOSE;
            end
          end
        end
        // Load: card words go to the drive, translated if legacy.
        if (op_q == OP_LOAD) begin
          if (dwv_q && dw_ready) begin
            dwv_d = 1'b0;
            if (bl_q) begin
              st_d = ST_CLOSE;
            end
          end
          if (take_b) begin
            bl_d = cr_last;
            if (cr_legacy && !cr_diff) begin
              tc_d = TRIP_LEGACY;  // RULE16
              st_d = ST_DONE;
            end else if (cr_legacy && !par_exists) begin
              if (cr_last) begin  // RULE17
                st_d = ST_CLOSE;
              end
            end else begin
              dwv_d = 1'b1;  // RULE6
              dwi_d = cr_id;
              dwd_d = clamped;  // RULE18
            end
          end
        end
        // Compare: one word from each side, then check.
        if (op_q == OP_COMPARE) begin
          if (take_a) begin
            af_d = 1'b1;
            ai_d = src_id;
            ad_d = src_val;
          end
          if (take_b) begin
            bf_d = 1'b1;
            bi_d = cr_id;
            bd_d = cr_val;
            bl_d = cr_last;
          end
          if (af_q && bf_q) begin
            af_d = 1'b0;
            bf_d = 1'b0;
            if (ai_q != bi_q || ad_q != bd_q) begin
              tc_d = TRIP_COMPARE;  // RULE8
              st_d = ST_DONE;
            end else if (bl_q) begin
              st_d = ST_CLOSE;
            end
          end
        end
      end
      ST_CLOSE: begin
        fin_d = 1'b1;
        if (card_done) begin
          st_d  = ST_DONE;
          fin_d = 1'b0;
          if (op_q == OP_COMPARE) begin
            cmd_d = CCI_CMD_RST;  // RULE8
          end
        end
      end
      ST_DONE: begin
        st_d  = ST_IDLE;
        req_d = 1'b0;  // RULE14
      end
      default: st_d = ST_IDLE;
    endcase
    // Card failure or removal aborts any open transfer.
    if (st_q inside {ST_XFER, ST_CLOSE}) begin
      if (!cp_q) begin
        tc_d = TRIP_REMOVED;  // RULE15
        st_d = ST_DONE;
      end else if (card_err) begin
        tc_d = TRIP_CARD;
        st_d = ST_DONE;
      end
      if (st_d == ST_DONE) begin
        trip_d = (tc_d != TRIP_NONE);
        fin_d  = 1'b0;
      end
    end
    if (st_d != ST_XFER) begin
      cwv_d = 1'b0;
      dwv_d = 1'b0;
      af_d  = 1'b0;
      bf_d  = 1'b0;
    end
    // Ready only while the slot is free, keyed on the op being entered,
    // so the previous op never takes a word that nobody consumes.
    srdy_d = (st_d == ST_XFER) &&
             ((op_d inside {OP_SAVE_BOOT, OP_SAVE_PAR, OP_SAVE_PRG} &&
               !cwv_d && !(take_a && src_last)) ||
              (op_d == OP_COMPARE && !af_d));
    crdy_d = (st_d == ST_XFER) &&
             ((op_d == OP_LOAD && !dwv_d && !(take_b && cr_last)) ||
              (op_d == OP_COMPARE && !bf_d && !(take_b && cr_last)));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;   cmd_q <= CCI_CMD_RST; op_q <= OP_NONE;
      blk_q <= 10'd0;    tc_q <= TRIP_NONE;    trip_q <= 1'b0;
      ro_q <= 1'b0;      warn_q <= 1'b0;       req_q <= 1'b0;
      fin_q <= 1'b0;     srdy_q <= 1'b0;       crdy_q <= 1'b0;
      cwv_q <= 1'b0;     cwi_q <= 16'h0000;    cwd_q <= 32'h0000_0000;
      dwv_q <= 1'b0;     dwi_q <= 16'h0000;    dwd_q <= 32'h0000_0000;
      af_q <= 1'b0;      ai_q <= 16'h0000;     ad_q <= 32'h0000_0000;
      bf_q <= 1'b0;      bi_q <= 16'h0000;     bd_q <= 32'h0000_0000;
      al_q <= 1'b0;      bl_q <= 1'b0;
    end else begin
      st_q <= st_d;      cmd_q <= cmd_d;       op_q <= op_d;
      blk_q <= blk_d;    tc_q <= tc_d;         trip_q <= trip_d;
      ro_q <= ro_d;      warn_q <= warn_d;     req_q <= req_d;
      fin_q <= fin_d;    srdy_q <= srdy_d;     crdy_q <= crdy_d;
      cwv_q <= cwv_d;    cwi_q <= cwi_d;       cwd_q <= cwd_d;
      dwv_q <= dwv_d;    dwi_q <= dwi_d;       dwd_q <= dwd_d;
      af_q <= af_d;      ai_q <= ai_d;         ad_q <= ad_d;
      bf_q <= bf_d;      bi_q <= bi_d;         bd_q <= bd_d;
      al_q <= al_d;      bl_q <= bl_d;
    end
  end

  // Outputs straight from flops.
  assign prdata    = prd_q;
  assign pready    = prdy_q;
  assign pslverr   = perr_q;
  assign card_req  = req_q;
  assign card_op   = op_q;
  assign card_blk  = blk_q;
  assign card_fin  = fin_q;
  assign src_ready = srdy_q;
  assign cw_valid  = cwv_q;
  assign cw_id     = cwi_q;
  assign cw_val    = cwd_q;
  assign cr_ready  = crdy_q;
  assign dw_valid  = dwv_q;
  assign dw_id     = dwi_q;
  assign dw_val    = dwd_q;
  assign busy      = req_q;
  assign trip      = trip_q;
  assign trip_code = tc_q;
  assign ro_flag   = ro_q;
  assign warn_flag = warn_q;

endmodule : cci_card_cmd
`default_nettype wire

// File: cci_pkg.sv
// Constants and types for the card command interpreter.
// Assumes one 250 MHz clock and an APB master with 32-bit data.
// Operation
// RULE1: An operation runs only when a drive reset follows the code write; here a write of the CTRL exec bit also starts one.
// RULE2: Code 2001 saves all parameters to block 001, marked bootable.
// RULE3: Code 4yyy saves all parameters, option modules too, to block yyy.
// RULE4: A 4yyy save keeps only parameters that differ from defaults.
// RULE5: Code 5yyy saves the user program to block yyy.
// RULE6: Code 6yyy loads parameters or a program from block yyy.
// RULE7: Code 7yyy erases block yyy; 9999 formats, legacy card only.
// RULE8: Code 8yyy compares; match zeroes the code, mismatch trips.
// RULE9: Code 9666 sets warning suppression, 9555 clears it.
// RULE10: Code 9888 sets the read-only flag, 9777 clears it.
// RULE11: With read-only set only load codes and 9777 act.
// RULE12: The block field of a code spans 001 to 999.
// RULE13: Stored data lives in blocks 001 to 499.
// RULE14: The card is touched only during a commanded transfer.
// RULE15: Card removal during a transfer trips; operator retries.
// RULE16: Legacy sets translate only when saved as differences.
// RULE17: Translation skips parameters missing from this drive.
// RULE18: Translation clamps values into the target's range.
// RULE19: One operation at a time; no new code while busy.
package cci_pkg;

  // Register byte offsets.
  localparam logic [11:0] CCI_ADDR_CMD    = 12'h000;
  localparam logic [11:0] CCI_ADDR_CTRL   = 12'h004;
  localparam logic [11:0] CCI_ADDR_STATUS = 12'h008;

  // Command parameter layout and reset value.
  localparam int          CCI_CMD_W     = 14;
  localparam logic [13:0] CCI_CMD_RST   = 14'h0000;
  localparam logic [13:0] CCI_CMD_MAX   = 14'd9999;
  localparam int          CCI_CTRL_EXEC = 0;

  // Status field positions.
  localparam int CCI_ST_BUSY = 0;
  localparam int CCI_ST_RO   = 1;
  localparam int CCI_ST_WARN = 2;
  localparam int CCI_ST_CARD = 3;
  localparam int CCI_ST_TRIP = 8;

  // Special codes and block limits.
  localparam logic [13:0] CCI_CODE_BOOT   = 14'd2001;
  localparam logic [13:0] CCI_CODE_WCLR   = 14'd9555;
  localparam logic [13:0] CCI_CODE_WSET   = 14'd9666;
  localparam logic [13:0] CCI_CODE_RCLR   = 14'd9777;
  localparam logic [13:0] CCI_CODE_RSET   = 14'd9888;
  localparam logic [13:0] CCI_CODE_FMT    = 14'd9999;
  localparam logic [13:0] CCI_THOUSAND    = 14'd1000;
  localparam logic [9:0]  CCI_BLK_BOOT    = 10'd1;
  localparam logic [9:0]  CCI_BLK_MIN     = 10'd1;
  localparam logic [9:0]  CCI_BLK_FLD_MAX = 10'd999;
  localparam logic [9:0]  CCI_BLK_MAX     = 10'd499;

  // Decoded card operations.
  typedef enum logic [3:0] {
    OP_NONE, OP_SAVE_BOOT, OP_SAVE_PAR, OP_SAVE_PRG, OP_LOAD,
    OP_ERASE, OP_COMPARE, OP_FORMAT, OP_WARN_SET, OP_WARN_CLR,
    OP_RO_SET, OP_RO_CLR
  } cci_op_t;

  // Trip causes.
  typedef enum logic [2:0] {
    TRIP_NONE, TRIP_REMOVED, TRIP_COMPARE, TRIP_CARD, TRIP_NOCARD,
    TRIP_BLOCK, TRIP_UNSUP, TRIP_LEGACY
  } cci_trip_t;

  // Sequencer states, Gray along the usual path.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_CLOSE = 2'b11,
    ST_DONE  = 2'b10
  } cci_state_t;

endpackage : cci_pkg

// File: cci_cmd_if.sv
// Carries a command code to the decoder and the decoded operation back.
// Assumes both ends share one clock; the decode is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface cci_cmd_if;
  import cci_pkg::*;
  logic [13:0] code;
  cci_op_t     op;
  logic [9:0]  blk;
  modport dec (input code, output op, output blk);
  modport use_ (output code, input op, input blk);
endinterface : cci_cmd_if
`default_nettype wire

// File: cci_decode.sv
// Splits a decimal command code into operation and block number.
// Assumes the code is already limited to 0 to 9999.
`timescale 1ns/1ps
`default_nettype none
module cci_decode (
  cci_cmd_if.dec c
);
  import cci_pkg::*;

  logic [13:0] lead;
  logic [13:0] rest;

  // Thousands digit selects the kind, the rest is the block field.
  always_comb begin
    lead  = c.code / CCI_THOUSAND;
    rest  = c.code - 14'(lead * CCI_THOUSAND);
    c.blk = rest[9:0];  // RULE12
    unique case (lead[3:0])
      4'd2:    c.op = (c.code == CCI_CODE_BOOT) ? OP_SAVE_BOOT : OP_NONE;
      4'd4:    c.op = OP_SAVE_PAR;  // RULE3
      4'd5:    c.op = OP_SAVE_PRG;  // RULE5
      4'd6:    c.op = OP_LOAD;  // RULE6
      4'd7:    c.op = OP_ERASE;  // RULE7
      4'd8:    c.op = OP_COMPARE;  // RULE8
      4'd9: begin
        unique case (c.code)
          CCI_CODE_WCLR: c.op = OP_WARN_CLR;  // RULE9
          CCI_CODE_WSET: c.op = OP_WARN_SET;  // RULE9
          CCI_CODE_RCLR: c.op = OP_RO_CLR;  // RULE10
          CCI_CODE_RSET: c.op = OP_RO_SET;  // RULE10
          CCI_CODE_FMT:  c.op = OP_FORMAT;  // RULE7
          default:       c.op = OP_NONE;
        endcase
      end
      default: c.op = OP_NONE;
    endcase
    // The block field of non-block codes is meaningless.
    if (c.op == OP_SAVE_BOOT) begin
      c.blk = CCI_BLK_BOOT;  // RULE2
    end
  end

endmodule : cci_decode
`default_nettype wire

// File: cci_card_props.sv
// Concurrent checks on the ports of the card command interpreter.
// Assumes it is bound onto every cci_card_cmd instance by name.
`timescale 1ns/1ps
`default_nettype none
module cci_card_props
  import cci_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             arst_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             card_present,
  input wire logic             card_is_sd,
  input wire logic             card_req,
  input wire cci_pkg::cci_op_t card_op,
  input wire logic [9:0]       card_blk,
  input wire logic             card_fin,
  input wire logic             cw_valid,
  input wire logic             cr_ready,
  input wire logic             trip,
  input wire logic             ro_flag
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("late bus answer");
  property p_stand;
    pready |=> !pready;
  endproperty
  a_stand: assert property (p_stand) else $error("ready held too long");
  property p_ro;
    ro_flag && $rose(card_req) |-> card_op == OP_LOAD;
  endproperty
  a_ro: assert property (p_ro) else $error("card op while read-only");
  property p_quiet;
    cw_valid || cr_ready |-> card_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("card used unasked");
  property p_boot;
    card_req && card_op == OP_SAVE_BOOT |-> card_blk == 10'd1;
  endproperty
  a_boot: assert property (p_boot) else $error("boot save off block 1");
  property p_fmt;
    card_fin && card_op == OP_FORMAT |-> !card_is_sd;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format run on SD");
  property p_drop;
    $rose(trip) |-> ##[0:3] !card_req;
  endproperty
  a_drop: assert property (p_drop) else $error("card held after trip");
  property p_rm;
    card_req && !card_present |-> ##[1:8] trip;
  endproperty
  a_rm: assert property (p_rm) else $error("no trip on removal");
  property p_hold;
    card_req && $past(card_req) |-> $stable(card_op) && $stable(card_blk);
  endproperty
  a_hold: assert property (p_hold) else $error("op changed in run");

  // Main scenarios seen at least once.
  c_trip: cover property ($rose(trip));
  c_fmt: cover property (card_fin && card_op == OP_FORMAT);
  c_ro: cover property (ro_flag && card_req);
endmodule : cci_card_props

bind cci_card_cmd cci_card_props i_props (.*);
`default_nettype wire

// File: cci_card_model.sv
// Behavioural removable card returning one fixed stored word for any block.
// Assumes the interpreter's card ports on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cci_card_model #(
  parameter logic [15:0] WORD_ID  = 16'h0007,
  parameter logic [31:0] WORD_VAL = 32'h0000_1234
) (
  input  wire logic   ref_clk,
  input  wire logic   arst_n,
  input  wire logic   slow,
  input  wire logic   card_req,
  input  wire logic   card_fin,
  input  wire logic   cw_valid,
  output logic        cw_ready,
  output logic        cr_valid,
  output logic [15:0] cr_id,
  output logic [31:0] cr_val,
  output logic        cr_last,
  output logic        card_done,
  output int          cw_cnt
);
  int cnt_q;

  // Takes card words at half rate and times the end of an operation.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cw_ready <= 1'b0;
      cw_cnt   <= 0;
      cnt_q    <= 0;
    end else begin
      cw_ready <= !cw_ready && card_req;
      if (cw_valid && cw_ready) begin
        cw_cnt <= cw_cnt + 1;
      end
      cnt_q <= card_fin ? cnt_q + 1 : 0;
    end
  end

  // Done pulses once, soon or late; an idle card drives the inverted word with valid low.
  assign card_done = card_fin && (cnt_q == (slow ? 20 : 2));
  assign cr_valid  = card_req;
  assign cr_id     = card_req ? WORD_ID : ~WORD_ID;
  assign cr_val    = card_req ? WORD_VAL : ~WORD_VAL;
  assign cr_last   = card_req;
endmodule : cci_card_model
`default_nettype wire

// File: card_command_interpreter_test.sv
// Self-checking bench for the card command interpreter.
// Assumes cci_card_model as the card and drives the drive side itself.
`timescale 1ns/1ps
`default_nettype none
module card_command_interpreter_test;
  import cci_pkg::*;
  logic        ref_clk, arst_n, psel, penable, pwrite, drive_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src_val, src_dflt, cw_val, cr_val;
  logic [31:0] dw_val, par_min, par_max, rd;
  logic        pready, pslverr, card_present, card_is_sd, card_done;
  logic        card_err, card_req, card_fin, src_valid, src_last;
  logic        src_ready, cw_valid, cw_ready, cr_valid, cr_last;
  logic        cr_legacy, cr_diff, cr_ready, par_exists, dw_valid;
  logic        dw_ready, busy, trip, ro_flag, warn_flag, slow;
  logic        bsy_seen, err;
  logic [15:0] src_id, cw_id, cr_id, dw_id;
  logic [9:0]  card_blk, blk_seen;
  cci_op_t     card_op, op_seen;
  cci_trip_t   trip_code;
  int          cw_cnt, mismatches, cmp_count, n1;

  cci_card_cmd i_dut (.*);
  cci_card_model i_card (.*);

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic hang();
    mismatches++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes a code, pulses drive reset and waits for the run to end.
  task automatic run(input logic [13:0] code, input logic rm = 1'b0);
    int n;
    apb(1'b1, CCI_ADDR_CMD, {18'h0_0000, code});
    @(posedge ref_clk);
    drive_reset <= 1'b1;
    @(posedge ref_clk);
    drive_reset <= 1'b0;
    @(posedge ref_clk);
    op_seen  = card_op;
    blk_seen = card_blk;
    bsy_seen = busy;
    if (rm) begin
      repeat (4) @(posedge ref_clk);
      card_present <= 1'b0;
    end
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) hang();
  endtask : run

  task automatic t_regs();
    apb(1'b0, CCI_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1'b1, CCI_ADDR_CMD, 32'h0000_2710);
    chk(err, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, CCI_ADDR_CMD, 32'd4008);
    repeat (3) @(posedge ref_clk);
    chk(busy, 1'b0);
    $display("register test done");
  endtask : t_regs

  task automatic t_flags();
    run(CCI_CODE_WSET);
    chk(warn_flag, 1'b1);
    run(CCI_CODE_WCLR);
    chk(warn_flag, 1'b0);
    run(CCI_CODE_RSET);
    chk(ro_flag, 1'b1);
    run(14'd4001);
    chk(bsy_seen, 1'b0);
    run(14'd6002);
    chk(op_seen, OP_LOAD);
    chk(blk_seen, 10'd2);
    run(CCI_CODE_RCLR);
    chk(ro_flag, 1'b0);
    $display("flag test done");
  endtask : t_flags

  task automatic t_save();
    n1 = cw_cnt;
    run(14'd4005);
    chk(op_seen, OP_SAVE_PAR);
    chk(blk_seen, 10'd5);
    chk(cw_cnt - n1, 1);
    src_dflt <= 32'h0000_1234;
    run(14'd4006);
    chk(cw_cnt - n1, 1);
    run(CCI_CODE_BOOT);
    chk(op_seen, OP_SAVE_BOOT);
    chk(blk_seen, CCI_BLK_BOOT);
    run(14'd5007);
    chk(op_seen, OP_SAVE_PRG);
    $display("save test done");
  endtask : t_save

  task automatic t_cmp();
    run(14'd8003);
    apb(1'b0, CCI_ADDR_CMD, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(trip_code, TRIP_NONE);
    src_val <= 32'h0000_1235;
    run(14'd8003);
    chk(trip_code, TRIP_COMPARE);
    apb(1'b0, CCI_ADDR_CMD, 32'h0000_0000);
    chk(rd, 32'd8003);
    src_val <= 32'h0000_1234;
    $display("compare test done");
  endtask : t_cmp

  task automatic t_legacy();
    cr_legacy <= 1'b1;
    cr_diff   <= 1'b0;
    run(14'd6004);
    chk(trip_code, TRIP_LEGACY);
    cr_diff <= 1'b1;
    par_max <= 32'h0000_1000;
    run(14'd6004);
    chk(dw_val, 32'h0000_1000);
    chk(dw_id, 32'h0000_0007);
    par_exists <= 1'b0;
    par_max    <= 32'h0000_0800;
    run(14'd6004);
    chk(dw_val, 32'h0000_1000);
    {cr_legacy, par_exists} <= 2'b01;
    $display("legacy test done");
  endtask : t_legacy

  task automatic t_erase();
    run(14'd7500);
    chk(trip_code, TRIP_BLOCK);
    run(14'd7499);
    chk(op_seen, OP_ERASE);
    chk(trip_code, TRIP_NONE);
    card_is_sd <= 1'b1;
    run(CCI_CODE_FMT);
    chk(trip_code, TRIP_UNSUP);
    card_is_sd <= 1'b0;
    run(CCI_CODE_FMT);
    chk(op_seen, OP_FORMAT);
    slow <= 1'b1;
    run(14'd7010, 1'b1);
    chk(trip_code, TRIP_REMOVED);
    run(14'd7011);
    chk(trip_code, TRIP_NOCARD);
    card_present <= 1'b1;
    slow         <= 1'b0;
    repeat (4) @(posedge ref_clk);
    run(14'd7010);
    chk(trip_code, TRIP_NONE);
    $display("erase test done");
  endtask : t_erase

  // Reset, then the scenarios in turn.
  initial begin
    {arst_n, psel, penable, pwrite, drive_reset, slow} = '0;
    {card_is_sd, card_err, cr_legacy} = '0;
    {card_present, src_valid, src_last, cr_diff} = '1;
    {par_exists, dw_ready} = '1;
    paddr    = '0;
    pwdata   = '0;
    src_id   = 16'h0007;
    src_val  = 32'h0000_1234;
    src_dflt = 32'h0000_0099;
    par_min  = 32'h0000_0000;
    par_max  = 32'h7fff_ffff;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_regs();
    t_flags();
    t_save();
    t_cmp();
    t_legacy();
    t_erase();
    print_verdict();
  end
endmodule : card_command_interpreter_test
`default_nettype wire
